// >>> wdor_top.sv
// Implementation choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
module wdor_top #(
  parameter wdor_pkg::wdor_variant_t VARIANT = wdor_pkg::WDOR_VAR_A
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic subclock_pulse,
  output logic internal_reset,
  output logic irq
);

  localparam logic RUN_RST = (VARIANT == wdor_pkg::WDOR_VAR_B); // RULE_07 RULE_11

  wdor_tick_if ticks ();

  wdor_prescale u_prescale (
    .pclk(pclk),
    .presetn(presetn),
    .subclock_pulse(subclock_pulse),
    .ticks(ticks)
  );

  logic csr_we_reg, csr_we_next;
  logic wd_run_reg, wd_run_next;
  logic cks_reg, cks_next;
  logic [wdor_pkg::TMW_W-1:0] tmw_sel_reg, tmw_sel_next;
  logic [wdor_pkg::COUNT_W-1:0] count_reg, count_next;
  logic ovf_reg, ovf_next;
  logic stat_reg, stat_next;
  logic mask_reg, mask_next;
  logic irq_reg, irq_next;
  logic [31:0] prdata_reg, prdata_next;

  logic wr_acc, rd_setup, mapped;
  logic wr_csr, wr_count, wr_mode, wr_stat, wr_mask;
  logic count_tick, ovf_event, run_write_ok;

  // ==========================================================
  // apb decode
  always_comb begin
    mapped = (paddr == wdor_pkg::OFF_CSR) || (paddr == wdor_pkg::OFF_COUNT) ||
             (paddr == wdor_pkg::OFF_MODE) || (paddr == wdor_pkg::OFF_STAT) ||
             (paddr == wdor_pkg::OFF_MASK);
    wr_acc = psel & penable & pwrite;
    rd_setup = psel & ~penable & ~pwrite;
    wr_csr = wr_acc & (paddr == wdor_pkg::OFF_CSR);
    wr_count = wr_acc & (paddr == wdor_pkg::OFF_COUNT);
    wr_mode = wr_acc & (paddr == wdor_pkg::OFF_MODE);
    wr_stat = wr_acc & (paddr == wdor_pkg::OFF_STAT);
    wr_mask = wr_acc & (paddr == wdor_pkg::OFF_MASK);
  end

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = prdata_reg;

  // ==========================================================
  // clock source selection
  always_comb begin
    if (cks_reg) begin
      count_tick = ticks.sub_tick; // RULE_04
    end else if (VARIANT == wdor_pkg::WDOR_VAR_A) begin
      count_tick = ticks.sys_tick; // RULE_02 RULE_11
    end else begin
      count_tick = ticks.tmw_tick[tmw_sel_reg]; // RULE_03
    end
  end

  // ==========================================================
  // control and counter next state
  always_comb begin
    run_write_ok = wr_csr & csr_we_reg & ~pwdata[wdor_pkg::CSR_INH_BIT];
    csr_we_next = wr_csr ? pwdata[wdor_pkg::CSR_WE_BIT] : csr_we_reg;
    wd_run_next = run_write_ok ? pwdata[wdor_pkg::CSR_RUN_BIT] // RULE_05 RULE_10
                               : wd_run_reg;
    cks_next = wr_mode ? pwdata[wdor_pkg::MODE_CKS_BIT] : cks_reg;
    tmw_sel_next = wr_mode ?
      pwdata[wdor_pkg::MODE_TMW_LSB +: wdor_pkg::TMW_W] : tmw_sel_reg;
    ovf_event = wd_run_reg & count_tick & ~wr_count &
                (count_reg == wdor_pkg::COUNT_MAX); // RULE_08
    count_next = count_reg;
    if (wr_count) begin
      count_next = pwdata[wdor_pkg::COUNT_W-1:0];
    end else if (wd_run_reg && count_tick) begin
      count_next = count_reg + 1'b1; // RULE_01 RULE_09
    end
    ovf_next = ovf_event; // RULE_08
    stat_next = (stat_reg & ~(wr_stat & pwdata[wdor_pkg::STAT_OVF_BIT])) |
                ovf_event;
    mask_next = wr_mask ? pwdata[wdor_pkg::STAT_OVF_BIT] : mask_reg;
    irq_next = stat_next & mask_next;
  end

  // ==========================================================
  // read data
  always_comb begin
    prdata_next = prdata_reg;
    if (rd_setup) begin
      prdata_next = 32'h0000_0000;
      unique case (paddr)
        wdor_pkg::OFF_CSR: begin
          prdata_next[wdor_pkg::CSR_WE_BIT] = csr_we_reg;
          prdata_next[wdor_pkg::CSR_RUN_BIT] = wd_run_reg;
        end
        wdor_pkg::OFF_COUNT: begin
          prdata_next[wdor_pkg::COUNT_W-1:0] = count_reg;
        end
        wdor_pkg::OFF_MODE: begin
          prdata_next[wdor_pkg::MODE_CKS_BIT] = cks_reg;
          prdata_next[wdor_pkg::MODE_TMW_LSB +: wdor_pkg::TMW_W] = tmw_sel_reg;
        end
        wdor_pkg::OFF_STAT: begin
          prdata_next[wdor_pkg::STAT_OVF_BIT] = stat_reg;
        end
        wdor_pkg::OFF_MASK: begin
          prdata_next[wdor_pkg::STAT_OVF_BIT] = mask_reg;
        end
        default: begin
          prdata_next = 32'h0000_0000;
        end
      endcase
    end
  end

  // ==========================================================
  // registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      csr_we_reg <= 1'b0;
      wd_run_reg <= RUN_RST; // RULE_07 RULE_10
      cks_reg <= 1'b0;
      tmw_sel_reg <= wdor_pkg::TMW_RST;
      count_reg <= wdor_pkg::COUNT_RST;
      ovf_reg <= 1'b0;
      stat_reg <= 1'b0;
      mask_reg <= 1'b0;
      irq_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      csr_we_reg <= csr_we_next;
      wd_run_reg <= wd_run_next;
      cks_reg <= cks_next;
      tmw_sel_reg <= tmw_sel_next;
      count_reg <= count_next;
      ovf_reg <= ovf_next;
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      irq_reg <= irq_next;
      prdata_reg <= prdata_next;
    end
  end

  assign internal_reset = ovf_reg;
  assign irq = irq_reg;

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence ovf_pulse_s;
    (internal_reset && count_reg == 8'h00 && stat_reg) ##1 !internal_reset;
  endsequence

  sequence ovf_cause_s;
    wd_run_reg && count_tick && !wr_count && count_reg == 8'hFF;
  endsequence

  run_set_guard_a: assert property ($rose(wd_run_reg) |-> // RULE_05
    $past(wr_csr && csr_we_reg && !pwdata[1] && pwdata[2]))
    else $error("run bit set without guarded write");

  run_fall_guard_a: assert property ($fell(wd_run_reg) |-> // RULE_10
    $past(wr_csr && csr_we_reg && !pwdata[1] && !pwdata[2]))
    else $error("run bit cleared without guarded write");

  run_start_a: assert property ((wr_csr && csr_we_reg && !pwdata[1] && // RULE_06
    pwdata[2]) |=> wd_run_reg)
    else $error("guarded start write ignored");

  count_hold_a: assert property ((!wd_run_reg && !wr_count) |=> // RULE_09
    $stable(count_reg))
    else $error("counter moved while stopped");

  count_step_a: assert property ((wd_run_reg && count_tick && !wr_count) // RULE_01
    |=> count_reg == 8'($past(count_reg) + 8'h01))
    else $error("counter missed a step");

  overflow_rst_a: assert property (ovf_cause_s |=> ovf_pulse_s) // RULE_08
    else $error("overflow did not raise internal reset");

  reset_cause_a: assert property ($rose(internal_reset) |-> // RULE_08
    $past(wd_run_reg && count_reg == 8'hFF))
    else $error("internal reset without overflow");

  src_sys_a: assert property ((VARIANT == wdor_pkg::WDOR_VAR_A && // RULE_02
    wd_run_reg && !cks_reg && !wr_count) |=>
    (count_reg != $past(count_reg)) == $past(ticks.sys_tick))
    else $error("variant A source is not the system divider");

  src_tmw_a: assert property ((VARIANT == wdor_pkg::WDOR_VAR_B && // RULE_03
    wd_run_reg && !cks_reg && !wr_count) |=>
    (count_reg != $past(count_reg)) == $past(ticks.tmw_tick[tmw_sel_reg]))
    else $error("variant B source is not the selected tap");

  src_sub_a: assert property ((wd_run_reg && cks_reg && !wr_count) |=> // RULE_04
    (count_reg != $past(count_reg)) == $past(ticks.sub_tick))
    else $error("subclock source not followed");

  reset_run_a: assert property ($rose(presetn) |-> // RULE_07 RULE_11
    wd_run_reg == (VARIANT == wdor_pkg::WDOR_VAR_B))
    else $error("run bit wrong after reset");

endmodule : wdor_top

// >>> wdor_pkg.sv
// How it works
// [RULE_01] an eight-bit up-counter advances once per selected input pulse while the run bit is set.
// [RULE_02] on variant A with clock-select zero the input is the system clock divided by 8192.
// [RULE_03] on variant B with clock-select zero the input is the tap chosen by the timer W mode field.
// [RULE_04] with clock-select one the input is the subclock divided by 32 on both variants.
// [RULE_05] the run bit is set only by writing run 1 and inhibit 0 while write-enable is already 1.
// [RULE_06] software starts the watchdog with two writes: write-enable first, then the run bit.
// [RULE_07] on variant B the run bit comes out of reset set, so counting starts without a write.
// [RULE_08] an input pulse while the counter holds FF overflows it and raises the internal reset.
// [RULE_09] the counter holds whenever the run bit is zero.
// [RULE_10] on variant A the run bit clears on the reset pin; on both it clears on writing run 0 and inhibit 0 with write-enable 1.
// [RULE_11] a build parameter picks variant A or B, setting the zero-select source and reset run value.
package wdor_pkg;

  // ==========================================================
  // register map
  localparam logic [7:0] OFF_CSR = 8'h00;
  localparam logic [7:0] OFF_COUNT = 8'h04;
  localparam logic [7:0] OFF_MODE = 8'h08;
  localparam logic [7:0] OFF_STAT = 8'h0C;
  localparam logic [7:0] OFF_MASK = 8'h10;

  // ==========================================================
  // field positions
  localparam int CSR_WE_BIT = 0;
  localparam int CSR_INH_BIT = 1;
  localparam int CSR_RUN_BIT = 2;
  localparam int MODE_CKS_BIT = 0;
  localparam int MODE_TMW_LSB = 1;
  localparam int TMW_W = 2;
  localparam int STAT_OVF_BIT = 0;

  // ==========================================================
  // reset values and counts
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hFF;
  localparam logic [1:0] TMW_RST = 2'h0;
  localparam int COUNT_W = 8;
  localparam int SYS_DIV = 8192;
  localparam int SUB_DIV = 32;
  localparam int SYS_DIV_W = $clog2(SYS_DIV);
  localparam int SUB_DIV_W = $clog2(SUB_DIV);
  localparam int TMW_TAPS = 4;
  localparam int TMW_LOG2 [TMW_TAPS] = '{13, 10, 8, 6};

  typedef enum logic {WDOR_VAR_A, WDOR_VAR_B} wdor_variant_t;

endpackage : wdor_pkg

// >>> wdor_tick_if.sv
`timescale 1ns/1ps
interface wdor_tick_if;
  logic sys_tick;
  logic sub_tick;
  logic [wdor_pkg::TMW_TAPS-1:0] tmw_tick;
  modport src(output sys_tick, output sub_tick, output tmw_tick);
  modport dst(input sys_tick, input sub_tick, input tmw_tick);
endinterface : wdor_tick_if

// >>> wdor_prescale.sv
`timescale 1ns/1ps
module wdor_prescale (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic subclock_pulse,
  wdor_tick_if.src ticks
);

  logic [wdor_pkg::SYS_DIV_W-1:0] sys_cnt_reg;
  logic [wdor_pkg::SYS_DIV_W-1:0] sys_cnt_next;
  logic [wdor_pkg::SUB_DIV_W-1:0] sub_cnt_reg;
  logic [wdor_pkg::SUB_DIV_W-1:0] sub_cnt_next;

  // ==========================================================
  // free-running dividers
  always_comb begin
    sys_cnt_next = sys_cnt_reg + 1'b1;
    sub_cnt_next = subclock_pulse ? sub_cnt_reg + 1'b1 : sub_cnt_reg;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sys_cnt_reg <= '0;
      sub_cnt_reg <= '0;
    end else begin
      sys_cnt_reg <= sys_cnt_next;
      sub_cnt_reg <= sub_cnt_next;
    end
  end

  // ==========================================================
  // tick outputs
  assign ticks.sys_tick = &sys_cnt_reg; // RULE_02
  assign ticks.sub_tick = subclock_pulse & (&sub_cnt_reg); // RULE_04

  genvar g;
  generate
    for (g = 0; g < wdor_pkg::TMW_TAPS; g++) begin : g_tap
      assign ticks.tmw_tick[g] =
        &sys_cnt_reg[wdor_pkg::TMW_LOG2[g]-1:0]; // RULE_03
    end
  endgenerate

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sys_tick_spacing_a: assert property (ticks.sys_tick |=> !ticks.sys_tick [*8]) // RULE_02
    else $error("system tick repeated too soon");

endmodule : wdor_prescale

// >>> tb.sv
`timescale 1ns/1ps
module tb;
  // ==========================================================
  // signals
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic subclock_pulse = 1'h0;
  logic [31:0] prdata, prdata_b, ra, rb, c0, c1;
  logic pready, pslverr, internal_reset, irq, re;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  int ir_cnt = 0;
  always #12.5 pclk = ~pclk;
  wdor_top #(.VARIANT(wdor_pkg::WDOR_VAR_A)) DUT (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .subclock_pulse(subclock_pulse),
    .internal_reset(internal_reset), .irq(irq));
  wdor_top #(.VARIANT(wdor_pkg::WDOR_VAR_B)) DUT_B (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata_b), .pready(),
    .pslverr(), .subclock_pulse(subclock_pulse), .internal_reset(),
    .irq());
  // ==========================================================
  // helpers
  task report_and_stop;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : report_and_stop
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (internal_reset === 1'h1) ir_cnt <= ir_cnt + 1;
    if (cyc == 40000) begin
      err_total = err_total + 1;
      report_and_stop();
    end
  end
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, got);
      err_total++;
    end
  endtask : chk
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1) begin
      @(posedge pclk);
      n++;
    end
    ra = prdata;
    rb = prdata_b;
    re = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  task idle(input int n);
    repeat (n) @(posedge pclk);
  endtask : idle
  task pulses(input int n);
    repeat (n) begin
      @(posedge pclk);
      subclock_pulse <= 1'h1;
      @(posedge pclk);
      subclock_pulse <= 1'h0;
    end
    idle(4);
  endtask : pulses
  // ==========================================================
  // scenarios
  task t_reset_values;
    apb(1'h0, wdor_pkg::OFF_CSR, 32'h0);
    chk("csr a", 32'h0, ra);
    chk("csr b", 32'h4, rb);
    apb(1'h0, 8'h20, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, re});
    chk("unmapped data", 32'h0, ra);
    chk("pready", 32'h1, {31'h0, pready});
    apb(1'h0, wdor_pkg::OFF_STAT, 32'h0);
    chk("stat", 32'h0, ra);
  endtask : t_reset_values
  task t_start_guard;
    apb(1'h1, wdor_pkg::OFF_CSR, 32'h5);
    apb(1'h0, wdor_pkg::OFF_CSR, 32'h0);
    chk("csr one write", 32'h1, ra);
    apb(1'h1, wdor_pkg::OFF_CSR, 32'h5);
    apb(1'h0, wdor_pkg::OFF_CSR, 32'h0);
    chk("csr two writes", 32'h5, ra);
  endtask : t_start_guard
  task t_subclock;
    apb(1'h1, wdor_pkg::OFF_MODE, 32'h1);
    apb(1'h0, wdor_pkg::OFF_COUNT, 32'h0);
    c0 = ra;
    c1 = rb;
    pulses(64);
    apb(1'h0, wdor_pkg::OFF_COUNT, 32'h0);
    chk("count a sub", (c0 + 2) & 32'hFF, ra);
    chk("count b sub", (c1 + 2) & 32'hFF, rb);
  endtask : t_subclock
  task t_stop;
    apb(1'h1, wdor_pkg::OFF_CSR, 32'h3);
    apb(1'h0, wdor_pkg::OFF_CSR, 32'h0);
    chk("csr inhibited", 32'h5, ra);
    apb(1'h1, wdor_pkg::OFF_CSR, 32'h1);
    apb(1'h0, wdor_pkg::OFF_CSR, 32'h0);
    chk("csr cleared", 32'h1, ra);
    apb(1'h1, wdor_pkg::OFF_COUNT, 32'h10);
    pulses(64);
    apb(1'h0, wdor_pkg::OFF_COUNT, 32'h0);
    chk("count held", 32'h10, ra);
  endtask : t_stop
  task t_overflow;
    apb(1'h1, wdor_pkg::OFF_CSR, 32'h5);
    apb(1'h1, wdor_pkg::OFF_MASK, 32'h0);
    apb(1'h1, wdor_pkg::OFF_COUNT, 32'hFE);
    pulses(64);
    chk("reset pulses", 32'h1, ir_cnt);
    apb(1'h0, wdor_pkg::OFF_COUNT, 32'h0);
    chk("count wrap", 32'h0, ra);
    apb(1'h0, wdor_pkg::OFF_STAT, 32'h0);
    chk("stat set", 32'h1, ra);
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'h1, wdor_pkg::OFF_MASK, 32'h1);
    idle(2);
    chk("irq on", 32'h1, {31'h0, irq});
    apb(1'h1, wdor_pkg::OFF_STAT, 32'h1);
    idle(2);
    chk("irq cleared", 32'h0, {31'h0, irq});
  endtask : t_overflow
  task t_sysclk;
    apb(1'h1, wdor_pkg::OFF_MODE, 32'h0);
    apb(1'h0, wdor_pkg::OFF_COUNT, 32'h0);
    c0 = ra;
    c1 = rb;
    idle(8189);
    apb(1'h0, wdor_pkg::OFF_COUNT, 32'h0);
    chk("count a sys", (c0 + 1) & 32'hFF, ra);
    chk("count b tap0", (c1 + 1) & 32'hFF, rb);
    apb(1'h1, wdor_pkg::OFF_MODE, 32'h6);
    apb(1'h0, wdor_pkg::OFF_COUNT, 32'h0);
    c1 = rb;
    idle(189);
    apb(1'h0, wdor_pkg::OFF_COUNT, 32'h0);
    chk("count b tap3", (c1 + 3) & 32'hFF, rb);
  endtask : t_sysclk
  task t_pin_clear;
    presetn <= 1'h0;
    idle(2);
    presetn <= 1'h1;
    apb(1'h0, wdor_pkg::OFF_CSR, 32'h0);
    chk("csr a pin", 32'h0, ra);
    chk("csr b pin", 32'h4, rb);
  endtask : t_pin_clear
  // ==========================================================
  // main sequence
  initial begin
    idle(8);
    presetn <= 1'h1;
    t_reset_values();
    t_start_guard();
    t_subclock();
    t_stop();
    t_overflow();
    t_sysclk();
    t_pin_clear();
    report_and_stop();
  end
endmodule : tb
